// file: hdl/ewp_pkg.sv
// Purpose: Constants for the write-latch, status and protection block
// Assumes: SPI mode 0, byte frames shifted most significant bit first
// Notes: Status byte has no bus offset; it is reached by serial commands
// Overview of operation
// - No internal write unless latch already set
// - Set command sets latch, clear command clears
// - Latch cleared at powerup and after writes
// - Status read works anytime, even while busy
// - Status layout: guard enable, blocks, latch, busy
// - Busy flag one while internal write runs
// - Latch flag mirrors the write enable latch
// - Set and clear act despite protection whenever not busy
// - Block guard bits change only by status write
// - Block guard code selects protected upper range
// - Status write stores only enable and block bits
// - Guard enable decides whether protect pin matters
// - Pin protection needs pin low and enable set
// - Pin protection blocks only status byte writes
// - Latch gates all writes; blocks gate array writes, pin protection status writes
// - Array access during internal write is ignored
// - Powerup: standby, latch clear, output released
// - Latch set opcode is 0000 0110
// - Latch clear opcode is 0000 0100
// - Bits move msb first, sampled on rising clock
package ewp_pkg;
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_ARRAY_READ = 8'h03;
   localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
   // Status byte field positions
   localparam int SB_GUARD_EN = 7;
   localparam int SB_BLOCK_HI = 3;
   localparam int SB_BLOCK_LO = 2;
   localparam int SB_LATCH = 1;
   localparam int SB_BUSY = 0;
   localparam logic [2:0] NV_RESET = 3'h0;
   // Protected range starts for block codes 01 and 10
   localparam logic [10:0] QUARTER_BASE = 11'h600;
   localparam logic [10:0] HALF_BASE = 11'h400;
   // Frame lengths in serial clock bits
   localparam logic [5:0] BITS_STATUS_WR = 6'h10;
   localparam logic [5:0] BITS_ARRAY_HDR = 6'h18;
   // Internal write time, in microseconds, and cycles at 125 MHz
   localparam int WRITE_TIME_US = 5;
   localparam int CLK_MHZ = 125;
   localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
   typedef enum logic [1:0] {
      EWP_IDLE = 2'b00,
      EWP_BUSY = 2'b01
   } ewp_state_t;
endpackage

// file: hdl/ewp_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Destination clock and reset given
// Notes: First stage feeds only the second
`timescale 1ns/100ps
module ewp_sync
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level in and out
   input wire logic d,
   output logic q
);
   logic s1_r;
   logic s2_r;

   // Plain two stage chain
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule

// file: hdl/ewp_top.sv
// Purpose: Serial front end with write latch, status byte, protection
// Assumes: Serial clock idles low; frames end with chip select high
// Notes: Array storage is outside; this block grants array writes
`timescale 1ns/100ps
module ewp_top
   import ewp_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES
)
(
   // System clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial link, clocked by the host
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   // Hardware protect pin, active low
   input wire logic wp_n,
   // Array write grant to storage
   output logic arr_wr_go,
   output logic [10:0] arr_wr_addr,
   output logic arr_busy
);
   // Reset release chain
   logic rs1_r;
   logic rs2_r;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
      end
      else
      begin
         rs1_r <= 1'b1;
         rs2_r <= rs1_r;
      end
   end
   wire logic srst_n = rs2_r;
   default clocking sys_cb @(posedge clk);
   endclocking
   default disable iff (!srst_n);

   // Link domain: shift in bits on rising sck while selected
   logic [5:0] bcnt_r;
   logic [5:0] bcnt_nxt;
   logic [7:0] op_r;
   logic [7:0] op_nxt;
   logic [7:0] dat_r;
   logic [7:0] dat_nxt;
   logic [10:0] adr_r;
   logic [10:0] adr_nxt;
   // Status byte seen by the link, captured from sync copies
   logic [7:0] stat_sync;

   always_comb
   begin
      bcnt_nxt = bcnt_r;
      op_nxt = op_r;
      dat_nxt = dat_r;
      adr_nxt = adr_r;
      if (bcnt_r != 6'h3F)
         bcnt_nxt = bcnt_r + 6'h01;
      // Bits arrive msb first
      if (bcnt_r < 6'h08)
         op_nxt = {op_r[6:0], si};
      else if (bcnt_r < BITS_ARRAY_HDR && op_r == OP_ARRAY_WRITE)
         adr_nxt = {adr_r[9:0], si};
      dat_nxt = {dat_r[6:0], si};
   end

   // Frame logic clears asynchronously with chip select high
   always_ff @(posedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         bcnt_r <= 6'h00;
         op_r <= 8'h00;
         dat_r <= 8'h00;
         adr_r <= 11'h000;
      end
      else
      begin
         bcnt_r <= bcnt_nxt;
         op_r <= op_nxt;
         dat_r <= dat_nxt;
         adr_r <= adr_nxt;
      end
   end

   // Output shifts on falling sck; status read only
   logic [2:0] obit_r;
   logic so_en_r;
   wire logic rd_phase = (bcnt_r >= 6'h08) && (op_r == OP_STATUS_READ);
   always_ff @(negedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         obit_r <= 3'h7;
         so_en_r <= 1'b0;
         so_o <= 1'b0;
      end
      else
      begin
         so_en_r <= rd_phase;
         if (rd_phase)
         begin
            so_o <= stat_sync[obit_r]; // Bit 7 leaves first
            obit_r <= obit_r - 3'h1;
         end
      end
   end
   // Released at powerup and when deselected
   assign so_oe = so_en_r;

   // Frame result held after deselect; bit count must be exact, except array writes take one to four whole bytes past the header
   logic [5:0] fcnt_r;
   logic [7:0] fop_r;
   logic [7:0] fdat_r;
   logic [10:0] fadr_r;
   logic ftog_r;
   // Capture on each rising sck: last frame values
   always_ff @(posedge sck or negedge srst_n)
   begin
      if (!srst_n)
      begin
         fcnt_r <= 6'h00;
         fop_r <= 8'h00;
         fdat_r <= 8'h00;
         fadr_r <= 11'h000;
      end
      else
      begin
         fcnt_r <= bcnt_nxt;
         fop_r <= op_nxt;
         fdat_r <= dat_nxt;
         fadr_r <= adr_nxt;
      end
   end
   // Deselect event toggles; frame values are stable by then
   always_ff @(posedge cs_n or negedge srst_n)
   begin
      if (!srst_n)
         ftog_r <= 1'b0;
      else
         ftog_r <= ~ftog_r;
   end

   // Cross the deselect toggle into clk
   logic tog_s;
   logic tog_d_r;
   ewp_sync u_tog
   (
      .clk(clk),
      .rst_n(srst_n),
      .d(ftog_r),
      .q(tog_s)
   );
   logic wp_s;
   ewp_sync u_wp
   (
      .clk(clk),
      .rst_n(srst_n),
      .d(wp_n),
      .q(wp_s)
   );
   wire logic frame_end = tog_s ^ tog_d_r;

   // Core state in clk domain
   ewp_state_t st_r;
   ewp_state_t st_nxt;
   logic latch_r;
   logic latch_nxt;
   logic [2:0] nv_r;
   logic [2:0] nv_nxt;
   logic [2:0] nv_pend_r;
   logic [2:0] nv_pend_nxt;
   logic is_stat_r;
   logic is_stat_nxt;
   logic [15:0] wcnt_r;
   logic [15:0] wcnt_nxt;
   logic go_r;
   logic go_nxt;
   logic [10:0] wadr_r;
   logic [10:0] wadr_nxt;

   // Pin protection only with pin low and enable set
   wire logic pin_guard = nv_r[2] & ~wp_s;
   // Block guard decode
   logic blk_hit;
   always_comb
   begin
      unique case (nv_r[1:0])
         2'b00: blk_hit = 1'b0;
         2'b01: blk_hit = fadr_r >= QUARTER_BASE;
         2'b10: blk_hit = fadr_r >= HALF_BASE;
         2'b11: blk_hit = 1'b1;
      endcase
   end

   wire logic arr_len_ok = fcnt_r > BITS_ARRAY_HDR
      && fcnt_r[2:0] == 3'h0;

   always_comb
   begin
      st_nxt = st_r;
      latch_nxt = latch_r;
      nv_nxt = nv_r;
      nv_pend_nxt = nv_pend_r;
      is_stat_nxt = is_stat_r;
      wcnt_nxt = wcnt_r;
      go_nxt = 1'b0;
      wadr_nxt = wadr_r;
      unique case (st_r)
         EWP_IDLE:
         begin
            if (frame_end && fcnt_r == 6'h08)
            begin
               // Full opcode then deselect
               if (fop_r == OP_LATCH_SET)
                  latch_nxt = 1'b1;
               else if (fop_r == OP_LATCH_CLEAR)
                  latch_nxt = 1'b0;
            end
            else if (frame_end && fop_r == OP_STATUS_WRITE
               && fcnt_r == BITS_STATUS_WR && latch_r && !pin_guard)
            begin
               // Keep only enable and block bits
               nv_pend_nxt = {fdat_r[SB_GUARD_EN], fdat_r[SB_BLOCK_HI],
                  fdat_r[SB_BLOCK_LO]};
               is_stat_nxt = 1'b1;
               wcnt_nxt = 16'h0000;
               st_nxt = EWP_BUSY;
            end
            else if (frame_end && fop_r == OP_ARRAY_WRITE && arr_len_ok
               && latch_r && !blk_hit)
            begin
               is_stat_nxt = 1'b0;
               wadr_nxt = fadr_r;
               go_nxt = 1'b1;
               wcnt_nxt = 16'h0000;
               st_nxt = EWP_BUSY;
            end
         end
         EWP_BUSY:
         begin
            // Frames during the write are dropped
            wcnt_nxt = wcnt_r + 16'h0001;
            if (wcnt_r == 16'(WRITE_CYC - 1))
            begin
               if (is_stat_r)
                  nv_nxt = nv_pend_r;
               latch_nxt = 1'b0;
               st_nxt = EWP_IDLE;
            end
         end
         default: st_nxt = EWP_IDLE;
      endcase
   end

   // Latch cleared at reset as at powerup
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         tog_d_r <= 1'b0;
         st_r <= EWP_IDLE;
         latch_r <= 1'b0;
         nv_r <= NV_RESET;
         nv_pend_r <= NV_RESET;
         is_stat_r <= 1'b0;
         wcnt_r <= 16'h0000;
         go_r <= 1'b0;
         wadr_r <= 11'h000;
      end
      else
      begin
         tog_d_r <= tog_s;
         st_r <= st_nxt;
         latch_r <= latch_nxt;
         nv_r <= nv_nxt;
         nv_pend_r <= nv_pend_nxt;
         is_stat_r <= is_stat_nxt;
         wcnt_r <= wcnt_nxt;
         go_r <= go_nxt;
         wadr_r <= wadr_nxt;
      end
   end

   // Status byte; link reads it through two stages per bit
   logic [7:0] stat_w;
   assign stat_w = {nv_r[2], 3'h0, nv_r[1:0], latch_r,
      st_r == EWP_BUSY};
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_ss
         ewp_sync u_s
         (
            .clk(sck),
            .rst_n(srst_n),
            .d(stat_w[g]),
            .q(stat_sync[g])
         );
      end
   endgenerate

   assign arr_wr_go = go_r;
   assign arr_wr_addr = wadr_r;
   assign arr_busy = st_r == EWP_BUSY;

   // Clk side checks; clock and reset come from the defaults at the top
   a_go_latch: assert property (go_r |-> $past(latch_r))
      else $error("array write without latch");
   a_busy_end: assert property ($fell(arr_busy) |-> !latch_r)
      else $error("latch still set after write");
   a_blk_guard: assert property (go_r |-> nv_r[1:0] == 2'h0
      || (nv_r[1:0] == 2'h1 && wadr_r < QUARTER_BASE)
      || (nv_r[1:0] == 2'h2 && wadr_r < HALF_BASE))
      else $error("write granted into guarded block");
   a_nv_stable: assert property (
      !$past(arr_busy) |-> $stable(nv_r))
      else $error("block bits changed outside write");
   a_pin_guard: assert property (
      $rose(arr_busy) && $past(pin_guard) |-> !is_stat_r)
      else $error("status write under pin guard");
   a_busy_flag: assert property (
      arr_busy |-> stat_w[SB_BUSY] && stat_w[SB_LATCH])
      else $error("status flags wrong during write");
   a_unused: assert property (stat_w[6:4] == 3'h0)
      else $error("unused bits set");
   a_busy_len: assert property ($rose(arr_busy) |-> arr_busy[*8])
      else $error("write ended early");
endmodule

// file: test/ewp_host.sv
// Purpose: Host side of the serial link, framing commands for the bench
// Assumes: Mode 0 framing, 6 ns bit period, clock idle low between frames
// Notes: Read data is taken only while the device drives its output
`timescale 1ns/100ps
module ewp_host
(
   // Lines driven toward the device
   output logic sck,
   output logic cs_n,
   output logic si,
   // Lines from the device
   input wire logic so_o,
   input wire logic so_oe
);
   // Deselected and quiet until a frame starts
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // One frame of n bits, right aligned in d; last eight bits read back returned
   task automatic xfer(input logic [39:0] d, input int n,
                       output logic [7:0] rd);
      int i;
      rd = 8'h00;
      cs_n = 1'b0;
      #6;
      for (i = 0; i < n; i++)
      begin
         si = d[n - 1 - i];
         #3;
         // Released output must not pass for data
         if (i >= 8)
            rd = {rd[6:0], (so_oe === 1'b1) ? so_o : 1'bx};
         sck = 1'b1;
         #3;
         sck = 1'b0;
      end
      #3;
      cs_n = 1'b1;
      si = ~si; // Line does not keep the last bit once released
   endtask
endmodule

// file: test/ewp_top_tb.sv
// Purpose: Self-checking bench for the latch, status and guard block
// Assumes: Host model frames commands; write time shortened to 80 clocks
// Notes: Table rows first, then busy and mid-run reset cases
`timescale 1ns/100ps
module ewp_top_tb
   import ewp_pkg::*;
();
   localparam int WCYC = 80;
   localparam logic [7:0] SET = OP_LATCH_SET;
   localparam logic [7:0] CLR = OP_LATCH_CLEAR;
   localparam logic [7:0] RD = OP_STATUS_READ;
   localparam logic [7:0] SW = OP_STATUS_WRITE;
   localparam logic [7:0] WR = OP_ARRAY_WRITE;
   typedef struct packed {
      logic pre; logic wp; logic [5:0] n; logic [39:0] d;
      logic go; logic [10:0] a; logic [7:0] st;
   } ewp_row_t;
   logic clk, rst_n, wp_n, sck, cs_n, si, so_o, so_oe, go, busy;
   logic [10:0] addr, go_addr;
   logic [7:0] rd;
   int num_errors, comparisons, go_cnt, busy_cnt;
   // Pre-latch, pin, bit count, frame, grant, address, status after
   ewp_row_t rows [0:19] = '{
      '{1'b0, 1'b1, 6'h08, SET, 1'b0, 11'h000, 8'h02},
      '{1'b0, 1'b1, 6'h08, CLR, 1'b0, 11'h000, 8'h00},
      '{1'b0, 1'b1, 6'h20, {WR, 16'h0100, 8'hAA}, 1'b0, 11'h000, 8'h00},
      '{1'b0, 1'b1, 6'h28, {SET, WR, 16'h0100, 8'h55}, 1'b0, 11'h000, 8'h00},
      '{1'b1, 1'b1, 6'h20, {WR, 16'h0123, 8'h5A}, 1'b1, 11'h123, 8'h00},
      '{1'b1, 1'b1, 6'h1F, 40'h010091AD, 1'b0, 11'h000, 8'h02},
      '{1'b0, 1'b1, 6'h11, {SW, 8'h8C, 1'b0}, 1'b0, 11'h000, 8'h02},
      '{1'b0, 1'b1, 6'h10, {SW, 8'hFC}, 1'b0, 11'h000, 8'h8C},
      '{1'b1, 1'b1, 6'h20, {WR, 16'h0000, 8'h11}, 1'b0, 11'h000, 8'h8E},
      '{1'b0, 1'b0, 6'h10, {SW, 8'h00}, 1'b0, 11'h000, 8'h8E},
      '{1'b0, 1'b0, 6'h08, CLR, 1'b0, 11'h000, 8'h8C},
      '{1'b0, 1'b0, 6'h08, SET, 1'b0, 11'h000, 8'h8E},
      '{1'b0, 1'b1, 6'h10, {SW, 8'h84}, 1'b0, 11'h000, 8'h84},
      '{1'b1, 1'b0, 6'h20, {WR, 16'h05FF, 8'h33}, 1'b1, 11'h5FF, 8'h84},
      '{1'b1, 1'b0, 6'h20, {WR, 16'h0600, 8'h44}, 1'b0, 11'h000, 8'h86},
      '{1'b0, 1'b1, 6'h10, {SW, 8'h08}, 1'b0, 11'h000, 8'h08},
      '{1'b1, 1'b1, 6'h20, {WR, 16'h03FF, 8'h66}, 1'b1, 11'h3FF, 8'h08},
      '{1'b1, 1'b1, 6'h20, {WR, 16'h0400, 8'h77}, 1'b0, 11'h000, 8'h0A},
      '{1'b0, 1'b0, 6'h10, {SW, 8'h00}, 1'b0, 11'h000, 8'h00},
      '{1'b1, 1'b0, 6'h20, {WR, 16'h07FF, 8'h88}, 1'b1, 11'h7FF, 8'h00}
   };

   ewp_top #(.WRITE_CYC(WCYC)) ewp_top_inst (.clk(clk), .rst_n(rst_n),
      .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
      .wp_n(wp_n), .arr_wr_go(go), .arr_wr_addr(addr), .arr_busy(busy));
   ewp_host ewp_host_inst (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o),
      .so_oe(so_oe));

   // System clock, 8 ns period
   initial clk = 1'b0;
   always #4 clk = ~clk;

   // Grants and busy cycles, looked at mid-cycle where they are settled
   always @(negedge clk)
   begin
      if (go === 1'b1)
      begin
         go_cnt++;
         go_addr = addr;
      end
      if (busy === 1'b1)
         busy_cnt++;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Frame plus the gap that detection and spacing need
   task automatic send(input logic [39:0] d, input int n);
      @(posedge clk);
      #1;
      ewp_host_inst.xfer(d, n, rd);
      repeat (12) @(posedge clk);
   endtask

   // Bounded wait for the internal write to end
   task automatic settle();
      int k;
      for (k = 0; k < 300 && busy !== 1'b0; k++)
         @(posedge clk);
      check("busy idle", busy, 1'b0);
   endtask

   task automatic status(input logic [7:0] exp);
      send({RD, 8'h00}, 16);
      check("status", rd, exp);
   endtask

   task automatic final_report();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      rst_n = 1'b0;
      wp_n = 1'b1;
      num_errors = 0;
      comparisons = 0;
      go_cnt = 0;
      busy_cnt = 0;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (8) @(posedge clk);
      check("so_oe", so_oe, 1'b0);
      status(8'h00);
      foreach (rows[i])
      begin
         @(posedge clk);
         #1 wp_n = rows[i].wp;
         repeat (4) @(posedge clk); // Pin crosses a synchroniser
         if (rows[i].pre)
            send(SET, 8);
         go_cnt = 0;
         send(rows[i].d, rows[i].n);
         settle();
         check("grants", go_cnt, rows[i].go);
         if (rows[i].go)
            check("addr", go_addr, rows[i].a);
         status(rows[i].st);
      end
      // Status readable mid-write; a second write is ignored
      go_cnt = 0;
      busy_cnt = 0;
      send(SET, 8);
      send({WR, 16'h0010, 8'hC3}, 32);
      status(8'h03);
      send({WR, 16'h0020, 8'h3C}, 32);
      settle();
      check("grants", go_cnt, 1);
      check("busy", busy_cnt, WCYC);
      status(8'h00);
      // Second reset with the latch set
      send(SET, 8);
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (8) @(posedge clk);
      check("so_oe", so_oe, 1'b0);
      status(8'h00);
      final_report();
   end

   // Run should end near 18 us; cut a hang well after that
   initial
   begin
      #100000;
      num_errors++;
      final_report();
   end
endmodule
